// ===== rtl/parity_host.sv
// The register addresses and register access over Avalon-MM were left to the implementer.
`include "parity_host_defs.svh"

module parity_host
   import parity_host_pkg::*;
#(
   parameter int TIMEOUT_CYC = `TIMEOUT_NS / `CLK_NS
) (
   // clock and reset
   input wire logic i_ref_clk,
   input wire logic i_srst,
   // avalon-mm slave
   input wire logic [2:0] i_avs_address,
   input wire logic i_avs_read,
   input wire logic i_avs_write,
   input wire logic [31:0] i_avs_writedata,
   output logic [31:0] o_avs_readdata,
   output logic o_avs_waitrequest,
   // system bus toward the device
   output logic [17:0] o_bus_addr,
   output logic [1:0] o_bus_ctl,
   output logic o_bus_msyn,
   input wire logic i_bus_ssyn,
   input wire logic [15:0] i_bus_data,
   output logic [15:0] o_bus_data,
   output logic o_bus_data_oe,
   input wire logic i_bus_pb,
   input wire logic i_bus_pa,
   // internal memory bus toward the device
   output logic o_internal_data_present_strobe,
   input wire logic i_high_byte_parity_line,
   output logic o_high_byte_parity_line,
   output logic o_high_byte_parity_line_oe,
   input wire logic i_low_byte_parity_line,
   output logic o_low_byte_parity_line,
   output logic o_low_byte_parity_line_oe,
   input wire logic i_pause_clear_restore_pulse
);

   localparam int SETUP_CYC = (`SETUP_NS + `CLK_NS - 1) / `CLK_NS;
   localparam int PCLR_CYC = (`PCLR_NS + `CLK_NS - 1) / `CLK_NS;

   // -------------------------------------------------------------------
   // helpers
   // -------------------------------------------------------------------
   // device register address from strap index: base plus word step
   function automatic logic [17:0] csr_addr(input logic [3:0] idx);
      csr_addr = `CSR_BASE_ADDR | (18'(idx) << `CSR_WORD_SHIFT);
   endfunction : csr_addr

   // -------------------------------------------------------------------
   // input synchronisers: three flops, accept when stages two and three agree
   // -------------------------------------------------------------------
   logic [`SYNC_W-1:0] raw_in;
   logic [`SYNC_W-1:0] s1_reg;
   logic [`SYNC_W-1:0] s2_reg;
   logic [`SYNC_W-1:0] s3_reg;
   logic [`SYNC_W-1:0] filt_reg;
   assign raw_in = {i_bus_ssyn, i_bus_pb, i_bus_pa,
                    i_pause_clear_restore_pulse, i_high_byte_parity_line,
                    i_low_byte_parity_line, i_bus_data};

   always_ff @(posedge i_ref_clk) begin
      if (i_srst) begin
         s1_reg <= '0;
         s2_reg <= '0;
         s3_reg <= '0;
         filt_reg <= '0;
      end else begin
         s1_reg <= raw_in;
         s2_reg <= s1_reg;
         s3_reg <= s2_reg;
         for (int i = 0; i < `SYNC_W; i++) begin
            if (s2_reg[i] == s3_reg[i]) begin
               filt_reg[i] <= s3_reg[i];
            end
         end
      end
   end

   logic ssyn_f;
   logic pb_f;
   logic pa_f;
   logic pclr_f;
   logic [1:0] par_f;
   logic [15:0] data_f;
   assign {ssyn_f, pb_f, pa_f, pclr_f, par_f, data_f} = filt_reg;

   // -------------------------------------------------------------------
   // software registers
   // -------------------------------------------------------------------
   logic ack_reg;
   logic acc;
   logic [31:0] ctrl_reg;
   logic [15:0] wdata_reg;
   logic [15:0] rdata_reg;
   logic [1:0] stored_par_reg;
   logic done_reg;
   logic timeout_reg;
   logic errcode_reg;
   logic pclr_seen_reg;
   logic [7:0] pclr_width_reg;
   logic [1:0] wpar_reg;
   logic start;
   host_state_t state_reg;
   logic [31:0] status;

   assign acc = i_avs_read | i_avs_write;
   // one wait state on every access, then the answer
   assign o_avs_waitrequest = acc & ~ack_reg;
   assign start = ack_reg & i_avs_write & (i_avs_address == `REG_CTRL)
                  & i_avs_writedata[`CTRL_START] & (state_reg == ST_IDLE);

   assign status = {16'h0000, pclr_width_reg, wpar_reg,
                    pclr_width_reg >= 8'(PCLR_CYC), pclr_seen_reg,
                    errcode_reg, timeout_reg, done_reg,
                    state_reg != ST_IDLE};

   always_ff @(posedge i_ref_clk) begin
      if (i_srst) begin
         ack_reg <= 1'b0;
         o_avs_readdata <= 32'h0000_0000;
      end else begin
         ack_reg <= acc & ~ack_reg;
         if (acc & ~ack_reg) begin
            case (i_avs_address)
               `REG_CTRL: o_avs_readdata <= ctrl_reg;
               `REG_WDATA: o_avs_readdata <= {16'h0000, wdata_reg};
               `REG_RDATA: o_avs_readdata <= {16'h0000, rdata_reg};
               `REG_STATUS: o_avs_readdata <= status;
               `REG_PARITY: o_avs_readdata <= {30'h0, stored_par_reg};
               default: o_avs_readdata <= 32'h0000_0000; // unmapped
            endcase
         end
      end
   end

   // writable control registers; start bit is not stored
   always_ff @(posedge i_ref_clk) begin
      if (i_srst) begin
         ctrl_reg <= 32'h0000_0000;
         wdata_reg <= 16'h0000;
         stored_par_reg <= 2'b00;
      end else if (ack_reg & i_avs_write) begin
         case (i_avs_address)
            `REG_CTRL: begin
               ctrl_reg <= {24'h0, i_avs_writedata[`CTRL_IDX_HI:`CTRL_PAUSE],
                            i_avs_writedata[`CTRL_BYTE:`CTRL_WRITE], 1'b0};
            end
            `REG_WDATA: wdata_reg <= i_avs_writedata[15:0];
            `REG_PARITY: stored_par_reg <= i_avs_writedata[1:0];
            default: ;
         endcase
      end
   end

   // -------------------------------------------------------------------
   // bus cycle sequencer
   // -------------------------------------------------------------------
   bus_req_t req_reg;
   logic [15:0] cnt_reg;
   logic is_read;
   assign is_read = ~req_reg.ctl[1];

   always_ff @(posedge i_ref_clk) begin
      if (i_srst) begin
         state_reg <= ST_IDLE;
         req_reg <= '0;
         cnt_reg <= 16'h0000;
         o_bus_msyn <= 1'b0;
      end else begin
         case (state_reg)
            ST_IDLE: begin
               if (start) begin
                  req_reg.addr <= csr_addr(
                     i_avs_writedata[`CTRL_IDX_HI:`CTRL_IDX_LO]);
                  req_reg.ctl <= cycle_t'({i_avs_writedata[`CTRL_WRITE],
                     i_avs_writedata[`CTRL_WRITE] ?
                     i_avs_writedata[`CTRL_BYTE] :
                     i_avs_writedata[`CTRL_PAUSE]});
                  req_reg.data <= wdata_reg;
                  cnt_reg <= 16'h0000;
                  state_reg <= ST_SETUP;
               end
            end
            // address and data settle before master sync
            ST_SETUP: begin
               cnt_reg <= cnt_reg + 16'h0001;
               if (cnt_reg >= 16'(SETUP_CYC - 1)) begin
                  o_bus_msyn <= 1'b1;
                  cnt_reg <= 16'h0000;
                  state_reg <= ST_WAIT_SS;
               end
            end
            // a withheld slave sync ends here by timeout, not a hang
            ST_WAIT_SS: begin
               cnt_reg <= cnt_reg + 16'h0001;
               if (ssyn_f | (cnt_reg >= 16'(TIMEOUT_CYC - 1))) begin
                  o_bus_msyn <= 1'b0;
                  state_reg <= ST_RELEASE;
               end
            end
            ST_RELEASE: begin
               if (~ssyn_f) begin
                  state_reg <= ST_IDLE;
               end
            end
            default: state_reg <= ST_IDLE;
         endcase
      end
   end

   // results of a cycle; a new start clears the sticky flags
   always_ff @(posedge i_ref_clk) begin
      if (i_srst) begin
         done_reg <= 1'b0;
         timeout_reg <= 1'b0;
         errcode_reg <= 1'b0;
         wpar_reg <= 2'b00;
         rdata_reg <= 16'h0000;
      end else if (start) begin
         done_reg <= 1'b0;
         timeout_reg <= 1'b0;
         errcode_reg <= 1'b0;
      end else if ((state_reg == ST_WAIT_SS) &
                   (ssyn_f | (cnt_reg >= 16'(TIMEOUT_CYC - 1)))) begin
         done_reg <= 1'b1;
         timeout_reg <= ~ssyn_f;
         errcode_reg <= ssyn_f & pb_f & ~pa_f;
         if (is_read & ssyn_f) begin
            rdata_reg <= data_f;
         end
         if (~is_read) begin
            wpar_reg <= par_f; // generated parity
         end
      end
   end

   // pause-clear width meter; a pulse ending as start lands still counts
   logic pclr_d_reg;
   logic [7:0] pclr_cnt_reg;
   always_ff @(posedge i_ref_clk) begin
      if (i_srst) begin
         pclr_d_reg <= 1'b0;
         pclr_cnt_reg <= 8'h00;
         pclr_seen_reg <= 1'b0;
         pclr_width_reg <= 8'h00;
      end else begin
         pclr_d_reg <= pclr_f;
         if (pclr_f) begin
            pclr_cnt_reg <= (pclr_cnt_reg == 8'hFF) ? pclr_cnt_reg :
                            pclr_cnt_reg + 8'h01;
         end else begin
            pclr_cnt_reg <= 8'h00;
         end
         if (pclr_d_reg & ~pclr_f) begin
            pclr_seen_reg <= 1'b1;
            pclr_width_reg <= pclr_cnt_reg;
         end else if (start) begin
            pclr_seen_reg <= 1'b0;
         end
      end
   end

   // -------------------------------------------------------------------
   // pin drive
   // -------------------------------------------------------------------
   logic active;
   assign active = (state_reg == ST_SETUP) | (state_reg == ST_WAIT_SS);
   assign o_bus_addr = req_reg.addr;
   assign o_bus_ctl = req_reg.ctl;
   assign o_bus_data = req_reg.data;
   assign o_bus_data_oe = active & ~is_read;
   // memory end: flag read data present while master sync is up
   assign o_internal_data_present_strobe =
      (state_reg == ST_WAIT_SS) & is_read;
   // stored parity flows toward the device only on reads
   assign o_high_byte_parity_line = stored_par_reg[1];
   assign o_low_byte_parity_line = stored_par_reg[0];
   assign o_high_byte_parity_line_oe = active & is_read;
   assign o_low_byte_parity_line_oe = active & is_read;

   // -------------------------------------------------------------------
   // assertions
   // -------------------------------------------------------------------
   default clocking cb @(posedge i_ref_clk); endclocking
   default disable iff (i_srst);

   parity_dir_excl_a: assert property (
      !(o_high_byte_parity_line_oe && o_bus_data_oe))
      else $error("parity line driven during write");
   low_par_dir_a: assert property (
      o_low_byte_parity_line_oe == o_high_byte_parity_line_oe)
      else $error("parity line enables differ");
   strobe_read_only_a: assert property (
      o_internal_data_present_strobe |-> o_bus_msyn && is_read)
      else $error("strobe outside read cycle");
   start_to_msyn_a: assert property (
      start |-> ##1 (state_reg == ST_SETUP) ##[1:20] o_bus_msyn)
      else $error("master sync late after start");
   csr_window_a: assert property (
      o_bus_msyn |-> (o_bus_addr >= `CSR_BASE_ADDR) &&
                     (o_bus_addr <= (`CSR_BASE_ADDR | 18'o36)))
      else $error("address outside register window");
   msyn_stable_a: assert property (
      o_bus_msyn && $past(o_bus_msyn) |-> $stable(o_bus_addr))
      else $error("address moved under master sync");
   avs_wait_a: assert property (
      (i_avs_read || i_avs_write) && !ack_reg |=> !o_avs_waitrequest)
      else $error("more than one wait state on access");
   done_set_a: assert property (
      (state_reg == ST_WAIT_SS) && ssyn_f |=> done_reg)
      else $error("done not set after slave sync");

   read_cyc_c: cover property (
      o_internal_data_present_strobe ##[1:50] done_reg);
   write_cyc_c: cover property (o_bus_data_oe ##[1:50] done_reg);
   timeout_c: cover property (timeout_reg);
   errcode_c: cover property (errcode_reg);

endmodule : parity_host

// ===== common/parity_host_defs.svh
`ifndef PARITY_HOST_DEFS_SVH
`define PARITY_HOST_DEFS_SVH
// Function
// - Master writes a 16-bit control word; all defined bits read back.
// - Memory flags read data present; controller then starts checking.
// - High-byte parity line two-way: generated on writes, stored on reads.
// - Low-byte parity line behaves alike, covering data bits 7..0.

// -------------------------------------------------------------------
// device register window (octal, 18-bit bus address)
// -------------------------------------------------------------------
`define CSR_BASE_ADDR   18'o772100
`define CSR_WORD_SHIFT  1

// -------------------------------------------------------------------
// avalon register word indices and fields
// -------------------------------------------------------------------
`define REG_CTRL    3'h0
`define REG_WDATA   3'h1
`define REG_RDATA   3'h2
`define REG_STATUS  3'h3
`define REG_PARITY  3'h4
`define CTRL_START  0
`define CTRL_WRITE  1
`define CTRL_BYTE   2
`define CTRL_PAUSE  3
`define CTRL_IDX_LO 4
`define CTRL_IDX_HI 7
`define ST_BUSY     0
`define ST_DONE     1
`define ST_TIMEOUT  2
`define ST_ERRCODE  3
`define ST_PCLR     4
`define ST_PCLR_OK  5
`define ST_WPAR_LO  6
`define ST_WPAR_HI  7
`define ST_PW_LO    8
`define ST_PW_HI    15

// -------------------------------------------------------------------
// timing
// -------------------------------------------------------------------
`define CLK_NS        10
`define SETUP_NS      150
`define PCLR_NS       500
`define TIMEOUT_NS    10000
`define SYNC_W        22
`endif

// ===== common/parity_host_pkg.sv
package parity_host_pkg;
   // bus cycle kinds, driven on the two control lines
   typedef enum logic [1:0] {
      CYC_DATI  = 2'b00,
      CYC_DATIP = 2'b01,
      CYC_DATO  = 2'b10,
      CYC_DATOB = 2'b11
   } cycle_t;

   typedef enum logic [2:0] {
      ST_IDLE    = 3'b000,
      ST_SETUP   = 3'b001,
      ST_WAIT_SS = 3'b010,
      ST_RELEASE = 3'b011
   } host_state_t;

   // one bus request as it stands on the pins
   typedef struct packed {
      logic [17:0] addr;
      cycle_t ctl;
      logic [15:0] data;
   } bus_req_t;
endpackage : parity_host_pkg

// ===== tb/parity_dev_model.sv
`include "parity_host_defs.svh"

module parity_dev_model
   import parity_host_pkg::*;
#(
   parameter logic [3:0] STRAPS_OUT = 4'h5,
   parameter int PCLR_CYC = 50,
   parameter bit RESTORE = 1'b1
) (
   // clock, init and test controls
   input wire logic i_ref_clk,
   input wire logic i_srst,
   input wire logic i_mute,
   input wire logic i_slow,
   // bus from the host
   input wire bus_req_t i_req,
   input wire logic i_msyn,
   input wire logic i_strobe,
   input wire logic [1:0] i_par,
   // answers to the host
   output logic o_ssyn,
   output logic [15:0] o_rdata,
   output logic o_pb,
   output logic o_pa,
   output logic [1:0] o_par,
   output logic o_par_oe,
   output logic o_pclr
);
   timeunit 1ns;
   timeprecision 1ps;
   // -----------------------------------------------------------------
   // register decode: one strapped word in the window
   // -----------------------------------------------------------------
   localparam logic [17:0] CSR_ADDR =
      `CSR_BASE_ADDR | {13'h0000, STRAPS_OUT, 1'b0};
   localparam logic [15:0] RW_MASK = 16'h8fe5;
   logic [15:0] csr_reg;
   logic [15:0] mem [16];

   // one bus cycle; other window words act as memory so parity is exercised
   task automatic serve();
      logic [15:0] d;
      logic err;
      logic hit;
      hit = i_req.addr == CSR_ADDR;
      d = hit ? csr_reg & RW_MASK : mem[i_req.addr[4:1]];
      err = 1'b0;
      repeat (i_slow ? 20 : 2) @(posedge i_ref_clk);
      if (i_req.ctl[1]) begin
         o_par <= {~^i_req.data[15:8], ~^i_req.data[7:0]}
            ^ {2{csr_reg[2]}};
         o_par_oe <= 1'b1;
         d = i_req.ctl[0] ? {d[15:8], i_req.data[7:0]} : i_req.data;
         if (hit)
            csr_reg = d & RW_MASK;
         else
            mem[i_req.addr[4:1]] = d;
      end else if (i_strobe) begin
         err = !hit && (!(^{d[15:8], i_par[1]})
            || !(^{d[7:0], i_par[0]}));
         if (err) begin
            csr_reg[15] = 1'b1;
            csr_reg[11:5] = i_req.addr[17:11];
         end
         o_rdata <= d;
         o_pb <= err & csr_reg[0];
         o_pa <= 1'b0;
      end
      o_ssyn <= 1'b1;
      if (err && i_req.ctl == CYC_DATIP && RESTORE) begin
         o_pclr <= 1'b1;
         repeat (PCLR_CYC) @(posedge i_ref_clk);
         o_pclr <= 1'b0;
      end
      while (i_msyn) @(posedge i_ref_clk);
      // released data shows the inverse so stale values never match
      o_ssyn <= 1'b0;
      o_par_oe <= 1'b0;
      o_pb <= 1'b0;
      o_rdata <= ~d;
   endtask : serve

   // init keeps the captured address field
   initial begin
      csr_reg = 16'h0000;
      foreach (mem[i]) mem[i] = 16'h0000;
      {o_ssyn, o_pb, o_pa, o_par_oe, o_pclr} = 5'h00;
      o_rdata = 16'h0000;
      o_par = 2'h0;
      forever begin
         @(posedge i_ref_clk);
         if (i_srst)
            csr_reg = csr_reg & 16'h0fe0;
         else if (i_msyn && !i_mute)
            serve();
      end
   end
endmodule : parity_dev_model

// ===== tb/core_memory_parity_controller_tb_top.sv
`include "parity_host_defs.svh"

module core_memory_parity_controller_tb_top;
   import parity_host_pkg::*;
   timeunit 1ns;
   timeprecision 1ps;
   localparam logic [3:0] STRAP = 4'h5;
   logic ref_clk, srst, avs_read, avs_write, avs_wait, mute, slow;
   logic [2:0] avs_address;
   logic [31:0] avs_writedata, avs_readdata;
   logic msyn, ssyn, data_oe, pb, pa, strobe, pclr, dev_oe;
   logic hp_o, hp_oe, lp_o, lp_oe;
   logic [17:0] bus_addr;
   logic [1:0] bus_ctl, dev_par;
   logic [15:0] bus_wdata, bus_rdata;
   logic [15:0] mem_e [16];
   int fail_count = 0;
   int samples_checked = 0;
   // parity lines are pulled up when nobody drives them
   wire logic hp_w = dev_oe ? dev_par[1] : hp_oe ? hp_o : 1'b1;
   wire logic lp_w = dev_oe ? dev_par[0] : lp_oe ? lp_o : 1'b1;
   wire bus_req_t req = {bus_addr, bus_ctl, data_oe ? bus_wdata : 16'hffff};

   parity_host #(.TIMEOUT_CYC(50)) dut (
      .i_ref_clk(ref_clk), .i_srst(srst),
      .i_avs_address(avs_address), .i_avs_read(avs_read),
      .i_avs_write(avs_write), .i_avs_writedata(avs_writedata),
      .o_avs_readdata(avs_readdata), .o_avs_waitrequest(avs_wait),
      .o_bus_addr(bus_addr), .o_bus_ctl(bus_ctl), .o_bus_msyn(msyn),
      .i_bus_ssyn(ssyn), .i_bus_data(bus_rdata), .o_bus_data(bus_wdata),
      .o_bus_data_oe(data_oe), .i_bus_pb(pb), .i_bus_pa(pa),
      .o_internal_data_present_strobe(strobe),
      .i_high_byte_parity_line(hp_w), .o_high_byte_parity_line(hp_o),
      .o_high_byte_parity_line_oe(hp_oe),
      .i_low_byte_parity_line(lp_w), .o_low_byte_parity_line(lp_o),
      .o_low_byte_parity_line_oe(lp_oe), .i_pause_clear_restore_pulse(pclr));

   parity_dev_model #(.STRAPS_OUT(STRAP)) partner (
      .i_ref_clk(ref_clk), .i_srst(srst), .i_mute(mute), .i_slow(slow),
      .i_req(req), .i_msyn(msyn), .i_strobe(strobe), .i_par({hp_w, lp_w}),
      .o_ssyn(ssyn), .o_rdata(bus_rdata), .o_pb(pb), .o_pa(pa),
      .o_par(dev_par), .o_par_oe(dev_oe), .o_pclr(pclr));

   initial begin
      ref_clk = 1'b0;
      forever #5 ref_clk = ~ref_clk;
   end
   // -----------------------------------------------------------------
   // helpers
   // -----------------------------------------------------------------
   function automatic logic [1:0] par_of(input logic [15:0] d, input logic w);
      return {~^d[15:8], ~^d[7:0]} ^ {w, w};
   endfunction : par_of

   task automatic conclude();
      if (fail_count == 0 && samples_checked > 0)
         $display("Testbench passed");
      else
         $display("Testbench failed");
      $finish;
   endtask : conclude

   task automatic chk(input string nm, input logic [17:0] e,
         input logic [17:0] g);
      samples_checked++;
      if (g !== e) begin
         fail_count++;
         $display("Error %s expected %h seen %h", nm, e, g);
      end
   endtask : chk

   // avalon access: request held until waitrequest is sampled low
   task automatic av(input logic wr, input logic [2:0] a,
         input logic [31:0] d, output logic [31:0] q);
      @(posedge ref_clk);
      avs_address <= a;
      avs_writedata <= d;
      avs_write <= wr;
      avs_read <= !wr;
      do @(posedge ref_clk); while (avs_wait !== 1'b0);
      q = avs_readdata;
      avs_write <= 1'b0;
      avs_read <= 1'b0;
   endtask : av

   // one device bus cycle, then status and read data
   task automatic cyc(input cycle_t k, input logic [3:0] idx,
         input logic [15:0] wd, input logic [1:0] par,
         output logic [15:0] st, output logic [15:0] rd);
      logic [31:0] q;
      int n;
      slow <= 1'($urandom);
      av(1'b1, `REG_WDATA, {16'h0000, wd}, q);
      av(1'b1, `REG_PARITY, {30'h0, par}, q);
      av(1'b1, `REG_CTRL, {24'h0, idx, !k[1] && k[0], &k, k[1], 1'b1}, q);
      n = 0;
      do begin
         av(1'b0, `REG_STATUS, 32'h0, q);
         n++;
      end while (q[1:0] !== 2'b10 && n < 100);
      chk("cyc_done", 18'h1, {17'h0, q[1:0] === 2'b10});
      st = q[15:0];
      av(1'b0, `REG_RDATA, 32'h0, q);
      rd = q[15:0];
   endtask : cyc

   // watchdog: the whole sequence needs well under 10000 cycles
   initial begin
      repeat (40000) @(posedge ref_clk);
      fail_count++;
      conclude();
   end
   // -----------------------------------------------------------------
   // main sequence
   // -----------------------------------------------------------------
   initial begin
      logic [15:0] st, rd, d, e;
      logic [31:0] q;
      logic [17:0] a;
      void'($urandom(36738));
      {srst, avs_read, avs_write, mute, slow} = 5'h10;
      avs_address = 3'h0;
      avs_writedata = 32'h0000_0000;
      repeat (8) @(posedge ref_clk);
      srst <= 1'b0;
      av(1'b0, 3'h7, 32'h0, q);
      chk("unmapped", 18'h0, {2'h0, q[15:0]});
      // software registers read back what was written; start reads zero
      d = 16'($urandom);
      av(1'b1, `REG_WDATA, {16'h0000, d}, q);
      av(1'b0, `REG_WDATA, 32'h0, q);
      chk("wdata_rb", {2'h0, d}, q[17:0]);
      av(1'b1, `REG_CTRL, {24'h0, d[7:1], 1'b0}, q);
      av(1'b0, `REG_CTRL, 32'h0, q);
      chk("ctrl_rb", {10'h0, d[7:1], 1'b0}, q[17:0]);
      av(1'b1, `REG_PARITY, {30'h0, d[1:0]}, q);
      av(1'b0, `REG_PARITY, 32'h0, q);
      chk("parity_rb", {16'h0, d[1:0]}, q[17:0]);
      // sweep every strap index; the register forces wrong parity after it
      e = 16'h0000;
      for (int i = 0; i < 16; i++) begin
         d = 16'($urandom) | (i == STRAP ? 16'h0005 : 16'h0000);
         cyc(CYC_DATO, i[3:0], d, 2'h0, st, rd);
         a = `CSR_BASE_ADDR | {13'h0, i[3:0], 1'b0};
         chk("bus_addr", a, bus_addr);
         chk("wpar", {16'h0, par_of(d, e[2])}, {16'h0, st[7:6]});
         if (i == STRAP)
            e = d & 16'h8fe5;
         mem_e[i] = d;
      end
      for (int i = 0; i < 16; i++) begin
         cyc(CYC_DATI, i[3:0], 16'h0, par_of(mem_e[i], 1'b0), st, rd);
         d = i == STRAP ? e : mem_e[i];
         chk("rdata", {2'h0, d}, {2'h0, rd});
         chk("errcode", 18'h0, {17'h0, st[3]});
      end
      // wrong stored parity on both read kinds, reporting off and on
      for (int k = 0; k < 4; k++) begin
         cyc(CYC_DATO, STRAP, {15'h0, k[1]}, 2'h0, st, rd);
         d = {15'h0, k[1]};
         cyc(k[0] ? CYC_DATIP : CYC_DATI, 4'h0, 16'h0,
            par_of(mem_e[0], 1'b0) ^ 2'($urandom_range(1, 3)), st, rd);
         chk("errcode", {17'h0, k[1]}, {17'h0, st[3]});
         chk("pause_seen", {17'h0, k[0]}, {17'h0, st[4]});
         if (k[0]) begin
            chk("pause_ok", 18'h1, {17'h0, st[5]});
            a = 18'(`PCLR_NS / `CLK_NS);
            chk("pause_width", a, {10'h0, st[15:8]});
         end
         cyc(CYC_DATI, STRAP, 16'h0, 2'h0, st, rd);
         chk("csr", {2'h0, 16'h8fc0 | d}, {2'h0, rd});
      end
      // maintenance mode hangs the cycle until the host gives up
      mute <= 1'b1;
      cyc(CYC_DATI, STRAP, 16'h0, 2'h0, st, rd);
      chk("timeout", 18'h1, {17'h0, st[2]});
      mute <= 1'b0;
      srst <= 1'b1;
      repeat (3) @(posedge ref_clk);
      srst <= 1'b0;
      cyc(CYC_DATI, STRAP, 16'h0, 2'h0, st, rd);
      chk("csr_init", 18'h00fc0, {2'h0, rd});
      // byte write keeps the high byte
      d = 16'($urandom);
      e = 16'($urandom);
      cyc(CYC_DATO, 4'h1, d, 2'h0, st, rd);
      cyc(CYC_DATOB, 4'h1, e, 2'h0, st, rd);
      chk("wpar_b", {16'h0, par_of(e, 1'b0)}, {16'h0, st[7:6]});
      cyc(CYC_DATI, 4'h1, 16'h0, par_of({d[15:8], e[7:0]}, 1'b0), st, rd);
      chk("byte", {2'h0, d[15:8], e[7:0]}, {2'h0, rd});
      conclude();
   end
endmodule : core_memory_parity_controller_tb_top
